// ===== hdasp_pkg.sv
package hdasp_pkg;
	localparam logic [7:0] ADDR_DATA = 8'hd6;
	localparam logic [7:0] ADDR_CTRL = 8'hd7;
	localparam int BIT_RECEIVER_READY_FLAG = 7;
	localparam int BIT_TRANSMITTER_EMPTY_FLAG  = 6;
	localparam int BIT_RECEIVE_IRQ_ENABLE = 5;
	localparam int BIT_TRANSMIT_IRQ_ENABLE = 4;
	localparam int BIT_BR_HI = 3;
	localparam int BIT_BR_LO = 1;
	localparam int BIT_PTY   = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int OSC_HZ   = 8000000;
	localparam int CLK_HZ   = 25000000;
	localparam logic [2:0] STATES_LAST = 3'h7;
	localparam logic [3:0] BITS_10 = 4'h8;
	localparam logic [3:0] BITS_11 = 4'h9;
	localparam logic [2:0] SMP_A = 3'h2;
	localparam logic [2:0] SMP_B = 3'h3;
	localparam logic [2:0] SMP_C = 3'h4;
	localparam logic [15:0] DIV_BASE = 16'h0068;
	localparam logic [15:0] DIV_ODD  = 16'h0100;
	localparam int STATES_PER_BIT = 8;

	typedef enum logic [1:0] {
		HDASP_IDLE  = 2'b00,
		HDASP_START = 2'b01,
		HDASP_DATA  = 2'b11,
		HDASP_STOP  = 2'b10
	} hdasp_state_t;

	typedef struct packed {
		logic       rx_ready;
		logic       tx_empty;
		logic       rx_irq_en;
		logic       tx_irq_en;
		logic [2:0] baud;
		logic       pty;
	} hdasp_ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} hdasp_bus_t;

	function automatic logic [15:0] hdasp_div(input logic [2:0] code);
		unique case (code) // see [RL18]
			3'h0:    hdasp_div = 16'(DIV_BASE * 16'h0040);
			3'h1:    hdasp_div = 16'(DIV_BASE * 16'h0020);
			3'h2:    hdasp_div = 16'(DIV_BASE * 16'h0010);
			3'h3:    hdasp_div = 16'(DIV_BASE * 16'h0008);
			3'h4:    hdasp_div = 16'(DIV_BASE * 16'h0004);
			3'h5:    hdasp_div = DIV_ODD;
			3'h6:    hdasp_div = 16'(DIV_BASE * 16'h0002);
			default: hdasp_div = DIV_BASE;
		endcase
	endfunction : hdasp_div

	function automatic logic hdasp_parity(input logic [7:0] d);
		hdasp_parity = ^d;
	endfunction : hdasp_parity
endpackage : hdasp_pkg

// ===== hdasp_tick.sv
`timescale 1ns/1ps
module hdasp_tick
	import hdasp_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Rate select and tick out
	input  wire logic [2:0] baud,
	output logic            tick
);
	// Divides the sys_clk by the oscillator-relative divisor/8 scaled to sys_clk (see [RL6])
	// Accumulates OSC_HZ/8 per sys_clk cycle so rate is exact on average.
	logic [31:0] acc;
	logic [31:0] next_acc;
	logic        next_tick;
	logic [31:0] limit;

	always_comb begin
		// Both sides scaled down so the slowest rate still fits in 32 bits
		limit = 32'((64'(CLK_HZ) * 64'(hdasp_div(baud))) / 64'(STATES_PER_BIT * STATES_PER_BIT));
		next_acc = acc + 32'(OSC_HZ / STATES_PER_BIT);
		next_tick = 1'b0;
		if (next_acc >= limit) begin
			next_acc = next_acc - limit;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc  <= '0;
			tick <= 1'b0;
		end else begin
			acc  <= next_acc;
			tick <= next_tick;
		end
	end
endmodule : hdasp_tick

// ===== hdasp_top.sv
`timescale 1ns/1ps
// How it works
// [RL1] Half duplex; frame length 10 or 11 bits fixed by a strap option.
// [RL2] 10-bit frame carries eight data bits or seven plus auto even parity.
// [RL3] Starting a transmit aborts any reception in progress.
// [RL4] 11-bit frame inverts transmitted serial data.
// [RL5] Transmit pin follows port value unless engine output select is asserted.
// [RL6] Internal clock divided to eight times the baud rate.
// [RL7] Three samples per bit, two-of-three majority vote.
// [RL8] Start and stop bits generated by hardware; software gives eight or nine.
// [RL9] Software configures format and ninth bit before writing data.
// [RL10] Ninth bit kept until software changes it or a reception overwrites it.
// [RL11] Start low, data LSB first, stop high, then release pin.
// [RL12] Transmit end sets empty flag; zero or data write clears; one write interrupts.
// [RL13] Receiver watches falling edge, waits one bit time, then collects data.
// [RL14] Eight bits to data buffer; ninth bit or parity to control bit 0.
// [RL15] After stop bit time, buffer the character and set ready flag.
// [RL16] Bit 5 enables receive interrupt, bit 4 transmit; writes also load both flags.
// [RL17] Ready flag cleared by zero write; one write accepted and interrupts.
// [RL18] Baud field bits 3..1 selects divisor, 104 at code 7.
// [RL19] Baud change takes effect immediately.
// [RL20] 10-bit mode bit 0 enables parity; after reception it reads parity.
// [RL21] Software clears data bit 7 when auto parity is enabled.
// [RL22] Data read returns receive buffer; write starts send and clears empty.
// [RL23] Reset clears flags and enables, idles engines, releases pin.
module hdasp_top
	import hdasp_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Frame option strap, high selects 11-bit frame
	input  wire logic       frame_11,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// Serial pins
	input  wire logic       rx_pin,
	input  wire logic       port_tx_value,
	output logic            tx_pin,
	output logic            serial_output_select,
	// Interrupt requests to the core
	output logic            rx_irq,
	output logic            tx_irq
);
	hdasp_bus_t  bus;
	hdasp_ctrl_t ctrl;
	hdasp_ctrl_t next_ctrl;
	logic        tick;
	logic        opt11;
	logic        opt_taken;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// Strap caught once after reset release; format then stays fixed
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			opt_taken <= 1'b0;
			opt11     <= 1'b0;
		end else if (!opt_taken) begin
			opt_taken <= 1'b1;
			opt11     <= frame_11; // see [RL1]
		end
	end

	hdasp_tick u_tick (
		.sys_clk (sys_clk),
		.rst     (rst),
		.baud    (ctrl.baud), // see [RL19]
		.tick    (tick)
	);

	logic wr_data;
	logic wr_ctrl;
	assign wr_data = bus.wr && (bus.addr == ADDR_DATA);
	assign wr_ctrl = bus.wr && (bus.addr == ADDR_CTRL);

	// Transmitter
	hdasp_state_t tx_st;
	hdasp_state_t next_tx_st;
	logic [8:0]   tx_sh;
	logic [8:0]   next_tx_sh;
	logic [3:0]   tx_cnt;
	logic [3:0]   next_tx_cnt;
	logic [2:0]   tx_ph;
	logic [2:0]   next_tx_ph;
	logic         next_tx_pin;
	logic         next_oe;
	logic         tx_done;
	logic         tx_line;
	logic [3:0]   nbits;

	assign nbits = opt11 ? BITS_11 : BITS_10; // see [RL8]

	always_comb begin
		next_tx_st  = tx_st;
		next_tx_sh  = tx_sh;
		next_tx_cnt = tx_cnt;
		next_tx_ph  = tx_ph;
		tx_done     = 1'b0;
		tx_line     = 1'b1;
		unique case (tx_st)
			HDASP_IDLE:  tx_line = 1'b1;
			HDASP_START: tx_line = 1'b0;
			HDASP_DATA:  tx_line = tx_sh[0];
			HDASP_STOP:  tx_line = 1'b1;
		endcase
		if (tx_st != HDASP_IDLE && tick) begin
			next_tx_ph = tx_ph + 3'h1;
			if (tx_ph == STATES_LAST) begin
				unique case (tx_st)
					HDASP_START: next_tx_st = HDASP_DATA;
					HDASP_DATA: begin
						next_tx_sh  = {1'b0, tx_sh[8:1]}; // see [RL11]
						next_tx_cnt = tx_cnt + 4'h1;
						if (tx_cnt == nbits - 4'h1) begin
							next_tx_st = HDASP_STOP;
						end
					end
					HDASP_STOP: begin
						next_tx_st = HDASP_IDLE;
						tx_done    = 1'b1;
					end
					HDASP_IDLE: next_tx_st = HDASP_IDLE;
				endcase
			end
		end
		if (wr_data) begin
			// Last data bit: stored ninth bit in 11-bit mode, parity of low seven in auto mode
			next_tx_st  = HDASP_START; // see [RL22]
			next_tx_ph  = '0;
			next_tx_cnt = '0;
			next_tx_sh  = {ctrl.pty, bus.wdata}; // see [RL10]
			if (!opt11 && ctrl.pty) begin
				next_tx_sh[7] = hdasp_parity({1'b0, bus.wdata[6:0]}); // see [RL2]
			end
		end
		next_oe     = (next_tx_st != HDASP_IDLE); // see [RL5]
		next_tx_pin = next_oe ? ((opt11 ? ~tx_line_n(next_tx_st, next_tx_sh) : tx_line_n(next_tx_st, next_tx_sh))) : port_tx_value; // see [RL4]
	end

	function automatic logic tx_line_n(input hdasp_state_t s, input logic [8:0] sh);
		unique case (s)
			HDASP_START: tx_line_n = 1'b0;
			HDASP_DATA:  tx_line_n = sh[0];
			default:     tx_line_n = 1'b1;
		endcase
	endfunction : tx_line_n

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_st  <= HDASP_IDLE; // see [RL23]
			tx_sh  <= '0;
			tx_cnt <= '0;
			tx_ph  <= '0;
			tx_pin <= 1'b1;
			serial_output_select <= 1'b0;
		end else begin
			tx_st  <= next_tx_st;
			tx_sh  <= next_tx_sh;
			tx_cnt <= next_tx_cnt;
			tx_ph  <= next_tx_ph;
			tx_pin <= next_tx_pin;
			serial_output_select <= next_oe;
		end
	end

	// Receiver
	hdasp_state_t rx_st;
	hdasp_state_t next_rx_st;
	logic [8:0]   rx_sh;
	logic [8:0]   next_rx_sh;
	logic [3:0]   rx_cnt;
	logic [3:0]   next_rx_cnt;
	logic [2:0]   rx_ph;
	logic [2:0]   next_rx_ph;
	logic [2:0]   votes;
	logic [2:0]   next_votes;
	logic         rx_prev;
	logic         rx_done;
	logic         vote;
	logic [7:0]   rx_buf;
	logic [7:0]   next_rx_buf;
	logic         rx_ninth;

	assign vote = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]); // see [RL7]

	always_comb begin
		next_rx_st  = rx_st;
		next_rx_sh  = rx_sh;
		next_rx_cnt = rx_cnt;
		next_rx_ph  = rx_ph;
		next_votes  = votes;
		next_rx_buf = rx_buf;
		rx_done     = 1'b0;
		rx_ninth    = 1'b0;
		unique case (rx_st)
			HDASP_IDLE: begin
				if (rx_prev && !rx_pin && tx_st == HDASP_IDLE) begin
					next_rx_st = HDASP_START; // see [RL13]
					next_rx_ph = '0;
					next_rx_cnt = '0;
				end
			end
			default: begin
				if (tick) begin
					next_rx_ph = rx_ph + 3'h1;
					if (rx_ph == SMP_A) next_votes[0] = rx_pin;
					if (rx_ph == SMP_B) next_votes[1] = rx_pin;
					if (rx_ph == SMP_C) next_votes[2] = rx_pin;
					if (rx_ph == STATES_LAST) begin
						unique case (rx_st)
							HDASP_START: next_rx_st = HDASP_DATA;
							HDASP_DATA: begin
								next_rx_sh  = {vote, rx_sh[8:1]};
								next_rx_cnt = rx_cnt + 4'h1;
								if (rx_cnt == nbits - 4'h1) next_rx_st = HDASP_STOP;
							end
							HDASP_STOP: begin
								next_rx_st = HDASP_IDLE; // see [RL15]
								rx_done    = 1'b1;
								if (opt11) begin
									next_rx_buf = rx_sh[7:0];
									rx_ninth    = rx_sh[8]; // see [RL14]
								end else begin
									next_rx_buf = rx_sh[8:1];
									rx_ninth    = hdasp_parity(rx_sh[8:1]); // see [RL20]
								end
							end
							HDASP_IDLE: next_rx_st = HDASP_IDLE;
						endcase
					end
				end
			end
		endcase
		if (wr_data) begin
			next_rx_st = HDASP_IDLE; // see [RL3]
			rx_done    = 1'b0;
			next_rx_buf = rx_buf;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_st   <= HDASP_IDLE;
			rx_sh   <= '0;
			rx_cnt  <= '0;
			rx_ph   <= '0;
			votes   <= '0;
			rx_prev <= 1'b1;
			rx_buf  <= '0;
		end else begin
			rx_st   <= next_rx_st;
			rx_sh   <= next_rx_sh;
			rx_cnt  <= next_rx_cnt;
			rx_ph   <= next_rx_ph;
			votes   <= next_votes;
			rx_prev <= rx_pin;
			rx_buf  <= next_rx_buf;
		end
	end

	// Control register; hardware set wins over software clear
	logic next_rx_irq;
	logic next_tx_irq;
	logic [7:0] next_rdata;

	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = hdasp_ctrl_t'(bus.wdata); // see [RL16]
		end
		if (wr_data) next_ctrl.tx_empty = 1'b0; // see [RL12]
		if (tx_done) next_ctrl.tx_empty = 1'b1;
		if (rx_done) begin
			next_ctrl.rx_ready = 1'b1; // see [RL17]
			next_ctrl.pty      = rx_ninth;
		end
		next_rx_irq = next_ctrl.rx_ready && next_ctrl.rx_irq_en;
		next_tx_irq = next_ctrl.tx_empty && next_ctrl.tx_irq_en;
		next_rdata = '0;
		if (bus.rd && bus.addr == ADDR_DATA) next_rdata = rx_buf;
		if (bus.rd && bus.addr == ADDR_CTRL) next_rdata = ctrl;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl   <= hdasp_ctrl_t'(CTRL_RESET);
			rx_irq <= 1'b0;
			tx_irq <= 1'b0;
			rdata  <= '0;
		end else begin
			ctrl   <= next_ctrl;
			rx_irq <= next_rx_irq;
			tx_irq <= next_tx_irq;
			rdata  <= next_rdata;
		end
	end
endmodule : hdasp_top

// ===== hdasp_properties.sv
`timescale 1ns/1ps
module hdasp_properties
	import hdasp_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// Serial side
	input wire logic       frame_11,
	input wire logic       port_tx_value,
	input wire logic       tx_pin,
	input wire logic       serial_output_select,
	input wire logic       rx_irq,
	input wire logic       tx_irq
);
	logic        sel;
	logic        cwr;
	logic [2:0]  baud;
	logic [12:0] len;
	assign sel = serial_output_select;
	assign cwr = wr && addr == ADDR_CTRL;
	// Frame length is judged only at the fastest rate, the one the bench runs
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			baud <= 3'h0;
			len  <= 13'h0000;
		end else begin
			if (cwr)
				baud <= wdata[BIT_BR_HI:BIT_BR_LO];
			len <= sel ? len + 13'h0001 : 13'h0000;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_pin_port: assert property (
		!sel && $stable(port_tx_value) |-> tx_pin == port_tx_value) else $error("pin not port");
	a_start_bit: assert property (
		$rose(sel) |-> tx_pin == frame_11) else $error("no start bit");
	a_stop_bit: assert property (
		$fell(sel) |-> $past(tx_pin) != frame_11) else $error("no stop bit");
	a_frame_len: assert property (
		$fell(sel) && baud == 3'h7 |->
		(frame_11 ? len - 13'h0145 : len) inside {[13'h0c76:13'h0cee]}) else $error("bad length");
	a_write_sends: assert property (
		wr && addr == ADDR_DATA |=> sel ##1 !tx_irq) else $error("write did not send");
	a_read_slot: assert property (
		!rd |=> rdata == 8'h00) else $error("stray read data");
	a_soft_ready: assert property (
		cwr && wdata[BIT_RECEIVER_READY_FLAG] && wdata[BIT_RECEIVE_IRQ_ENABLE] |-> ##[1:2] rx_irq) else $error("no rx request");
	a_tx_first: assert property (
		sel && !wr |=> !$rose(rx_irq)) else $error("reception during send");
	c_sent: cover property ($fell(sel));
	c_recv: cover property ($rose(rx_irq));
	c_long: cover property ($rose(sel) && frame_11);
endmodule : hdasp_properties

bind hdasp_top hdasp_properties hdasp_chk (
	.sys_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .frame_11,
	.port_tx_value, .tx_pin, .serial_output_select, .rx_irq, .tx_irq
);

// ===== hdasp_remote.sv
`timescale 1ns/1ps
module hdasp_remote #(
	parameter int BIT = 325
) (
	// Line from the block
	input  wire logic sys_clk,
	input  wire logic line_in,
	input  wire logic sel,
	input  wire logic inv,
	// Line to the block, idles at mark
	output logic      line_out
);
	logic [8:0] got;
	initial line_out = 1'b1;
	// Mid-bit sampling rides out the divider's fractional jitter
	always begin
		@(posedge sel);
		repeat (BIT / 2) @(negedge sys_clk);
		for (int i = 0; i < 8 + inv; i++) begin
			repeat (BIT) @(negedge sys_clk);
			got[i] = line_in ^ inv;
		end
	end
	task automatic send(input logic [7:0] x);
		@(posedge sys_clk);
		line_out <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge sys_clk);
			line_out <= i < 8 ? x[i] : 1'b1;
		end
		repeat (BIT) @(posedge sys_clk);
	endtask : send
endmodule : hdasp_remote

// ===== tb_half_duplex_async_serial_port.sv
`timescale 1ns/1ps
module tb_half_duplex_async_serial_port
	import hdasp_pkg::*;
;
	// Design ports
	logic        sys_clk, rst, frame_11, wr, rd, rx_pin, port_tx_value;
	logic        tx_pin, sel, rx_irq, tx_irq;
	logic [7:0]  addr, wdata, rdata, v, d;
	// Bench state
	logic [31:0] lfsr = 32'h5ce2;
	int          err_total = 0;
	int          compares = 0;
	int          cyc = 0;
	hdasp_top dut_u (
		.sys_clk, .rst, .frame_11, .addr, .wdata, .wr, .rd, .rdata, .rx_pin,
		.port_tx_value, .tx_pin, .serial_output_select(sel), .rx_irq, .tx_irq
	);
	hdasp_remote far_u (.sys_clk, .line_in(tx_pin), .sel, .inv(frame_11), .line_out(rx_pin));
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : step
	task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [7:0] x);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= x;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		@(negedge sys_clk);
	endtask : wreg
	task automatic rreg(input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		v = rdata;
	endtask : rreg
	task automatic txd(input logic [7:0] x);
		wreg(ADDR_DATA, x);
		do @(negedge sys_clk); while (sel === 1'b1);
	endtask : txd
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// A frame is 3250 or 3575 cycles; the whole run needs well under this
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		rst = 1'b1;
		frame_11 = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		port_tx_value = 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rreg(ADDR_CTRL);
		chk("ctrl", 9'(v), 9'(CTRL_RESET));
		rreg(8'hd5);
		chk("unmapped", 9'(v), 9'h000);
		port_tx_value <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk("port pin", 9'(tx_pin), 9'h000);
		port_tx_value <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			lfsr = step(lfsr);
			d = k ? lfsr[7:0] & 8'h7f : lfsr[7:0];
			wreg(ADDR_CTRL, 8'h1e | 8'(k));
			txd(d);
			chk("sent", 9'(far_u.got[7:0]), 9'({k ? ^d[6:0] : d[7], d[6:0]}));
			chk("tx irq", 9'(tx_irq), 9'h001);
			rreg(ADDR_CTRL);
			chk("ctrl", 9'(v), 9'(8'h5e | 8'(k)));
		end
		wreg(ADDR_CTRL, 8'h2e);
		chk("tx irq", 9'(tx_irq), 9'h000);
		lfsr = step(lfsr);
		d = lfsr[7:0];
		far_u.send(d);
		do @(negedge sys_clk); while (rx_irq !== 1'b1);
		rreg(ADDR_DATA);
		chk("rx data", 9'(v), 9'(d));
		rreg(ADDR_CTRL);
		chk("rx ctrl", 9'(v), 9'({7'h57, ^d}));
		wreg(ADDR_CTRL, 8'h2e);
		chk("rx clr", 9'(rx_irq), 9'h000);
		wreg(ADDR_CTRL, 8'hae);
		chk("rx set", 9'(rx_irq), 9'h001);
		wreg(ADDR_CTRL, 8'h2e);
		fork
			far_u.send(8'h3c);
		join_none
		repeat (1200) @(posedge sys_clk);
		lfsr = step(lfsr);
		txd(lfsr[7:0]);
		chk("abort", 9'(far_u.got[7:0]), 9'(lfsr[7:0]));
		chk("no rx", 9'(rx_irq), 9'h000);
		@(posedge sys_clk);
		rst      <= 1'b1;
		frame_11 <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		wreg(ADDR_CTRL, 8'h0f);
		for (int k = 0; k < 2; k++) begin
			lfsr = step(lfsr);
			txd(lfsr[7:0]);
			chk("ninth", far_u.got, {1'b1, lfsr[7:0]});
		end
		wrap_up();
	end
endmodule : tb_half_duplex_async_serial_port
